// file: hdl/ubsi_map.vh
// Register offsets, field positions, reset values and encodings of the descriptor engine.
`ifndef UBSI_MAP_VH
`define UBSI_MAP_VH

// ---------------------------------------------------------------------------
// Register offsets (word addresses on the 8-bit register port)
// ---------------------------------------------------------------------------
`define UBSI_ADDR_TOP_FLAG     8'h00
`define UBSI_ADDR_TOP_EN       8'h01
`define UBSI_ADDR_ERR_FLAG     8'h02
`define UBSI_ADDR_ERR_EN       8'h03
`define UBSI_ADDR_USB_CTRL     8'h04
`define UBSI_ADDR_OTG_CTRL     8'h05
`define UBSI_ADDR_EP0_CTRL     8'h06
`define UBSI_ADDR_PWR_CTRL     8'h07
`define UBSI_ADDR_EP_STALL     8'h08
`define UBSI_ADDR_PP_PTR       8'h09
`define UBSI_ADDR_DESC_LO      8'h0A
`define UBSI_ADDR_DESC_HI      8'h0B

// ---------------------------------------------------------------------------
// Descriptor status word fields
// ---------------------------------------------------------------------------
`define UBSI_DW_OWN            15
`define UBSI_DW_TOGGLE         14
`define UBSI_DW_PID_HI         13
`define UBSI_DW_PID_LO         10
`define UBSI_DW_RSVD_HI        13
`define UBSI_DW_RSVD_LO        12
`define UBSI_DW_TGL_CHK        11
`define UBSI_DW_STALL          10
`define UBSI_DW_BC_HI          9

// ---------------------------------------------------------------------------
// Control and flag bit positions
// ---------------------------------------------------------------------------
`define UBSI_CTRL_ENGINE_EN    0
`define UBSI_CTRL_PP_RESET     1
`define UBSI_OTG_ENABLE        2
`define UBSI_OTG_DPLUS_PULLUP  7
`define UBSI_EP0_HANDSHAKE     0
`define UBSI_EP0_RX_EN         3
`define UBSI_PWR_ENGINE        0
`define UBSI_TOP_ERROR         1
`define UBSI_TOP_TRN_DONE      3
`define UBSI_TOP_STALL         7
`define UBSI_RESET_BYTE        8'h00

// ---------------------------------------------------------------------------
// Transaction results and handshake codes
// ---------------------------------------------------------------------------
`define UBSI_RES_DONE          2'h0
`define UBSI_RES_STALL         2'h1
`define UBSI_RES_IGNORE        2'h2
`define UBSI_RES_IDLE          2'h3
`define UBSI_PID_STALL         4'hE

`endif

// file: hdl/ubsi_desc_eval.v
// Combinational evaluation of one descriptor status word against a transaction.
`timescale 1ns/10ps

module ubsi_desc_eval (
  input  wire [15:0] desc_word,
  input  wire        host_mode,
  input  wire [3:0]  token_pid,
  input  wire [3:0]  result_pid,
  input  wire        data_toggle,
  input  wire [9:0]  actual_count,
  output reg  [1:0]  result,
  output reg  [15:0] new_word
);

`include "ubsi_map.vh"

  always @* begin
    result   = `UBSI_RES_DONE;
    new_word = desc_word;
    // RULE2 - ignore CPU-owned
    if (!desc_word[`UBSI_DW_OWN]) begin
      result = `UBSI_RES_IDLE;
    // RULE11 - stall keeps word
    end else if (desc_word[`UBSI_DW_STALL]) begin
      result = `UBSI_RES_STALL;
    // RULE9 - toggle mismatch discard
    // RULE10 - toggle used when enabled
    end else if (desc_word[`UBSI_DW_TGL_CHK] &&
                 (desc_word[`UBSI_DW_TOGGLE] != data_toggle)) begin
      result = `UBSI_RES_IGNORE;
    end else begin
      result = `UBSI_RES_DONE;
      // RULE25 - return to CPU
      // RULE23 - engine layout written
      new_word[`UBSI_DW_OWN] = 1'b0;
      // RULE3 - toggle bit meaning
      new_word[`UBSI_DW_TOGGLE] = data_toggle;
      // RULE4 - device token PID
      // RULE5 - host result PID
      new_word[`UBSI_DW_PID_HI:`UBSI_DW_PID_LO] = host_mode ? result_pid : token_pid;
      // RULE7 - actual byte count
      new_word[`UBSI_DW_BC_HI:0] = actual_count;
    end
  end

endmodule // ubsi_desc_eval

// file: hdl/ubsi_core.v
// Descriptor status, two-level interrupt flags and device-mode enable registers.
//
// Function
// RULE1 - CPU leaves engine-owned descriptor alone
// RULE2 - Engine ignores CPU-owned descriptor fields
// RULE3 - Toggle bit one means DATA1
// RULE4 - Device mode stores received token PID
// RULE5 - Host mode stores returned PID
// RULE6 - Software loads byte count first
// RULE7 - Completion writes actual byte count
// RULE8 - Software writes reserved bits zero
// RULE9 - Toggle check discards mismatched packets
// RULE10 - Toggle bit used only when checking
// RULE11 - Stall answers STALL, keeps descriptor
// RULE12 - Every STALL sets endpoint stall flag
// RULE13 - One shared interrupt output
// RULE14 - Error level feeds summary flag
// RULE15 - Flags hardware set, write-one clear
// RULE16 - Engine runs control status phase
// RULE17 - Pointer reset pulse clears pointers
// RULE18 - Software clears enables and flags
// RULE19 - Software enables engine and OTG
// RULE20 - Software arms endpoint zero
// RULE21 - Software powers up engine
// RULE22 - Pull-up bit drives D+ pull-up
// RULE23 - Two layouts share ownership bit
// RULE24 - Completion sets transfer-done flag
// RULE25 - Success returns descriptor to CPU
//
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/10ps

module ubsi_core #(
  parameter EP_COUNT = 16
) (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata,
  input  wire        txn_valid,
  input  wire [3:0]  txn_endpoint,
  input  wire [3:0]  txn_token_pid,
  input  wire [3:0]  txn_result_pid,
  input  wire        txn_toggle,
  input  wire [9:0]  txn_count,
  input  wire        txn_host_mode,
  input  wire        txn_is_setup,
  input  wire [7:0]  err_events,
  output reg         txn_done,
  output reg  [1:0]  txn_result,
  output reg         status_phase_auto,
  output wire        irq,
  output wire        dplus_pullup_enable,
  output wire        engine_active
);

`include "ubsi_map.vh"

  // -------------------------------------------------------------------------
  // Register state
  // -------------------------------------------------------------------------
  reg  [7:0]          top_irq_flag_reg_q;
  reg  [7:0]          top_irq_enable_reg_q;
  reg  [7:0]          error_irq_flag_reg_q;
  reg  [7:0]          error_irq_enable_reg_q;
  reg  [7:0]          usb_control_reg_q;
  reg  [7:0]          on_the_go_control_reg_q;
  reg  [7:0]          endpoint_zero_control_reg_q;
  reg  [7:0]          power_control_reg_q;
  reg  [EP_COUNT-1:0] endpoint_stall_flag_q;
  reg  [EP_COUNT-1:0] pingpong_ptr_q;
  reg  [15:0]         descriptor_status_word_q;
  wire [1:0]          eval_result;
  wire [15:0]         eval_word;
  wire                wr_top_flag;
  wire                wr_err_flag;
  wire                wr_stall;
  wire                txn_take;
  wire                stall_event;
  wire                done_event;
  wire [EP_COUNT-1:0] ep_onehot;
  wire [7:0]          top_set;

  // -------------------------------------------------------------------------
  // Next values and masks
  // -------------------------------------------------------------------------
  wire                wr_desc_lo;
  wire                wr_desc_hi;
  wire                error_pending;
  wire [7:0]          top_clear;
  wire [7:0]          error_clear;
  wire [EP_COUNT-1:0] stall_clear;
  wire [EP_COUNT-1:0] stall_set;
  reg  [15:0]         descriptor_status_word_d;
  reg  [7:0]          top_irq_flag_reg_d;
  reg  [7:0]          error_irq_flag_reg_d;
  reg  [EP_COUNT-1:0] endpoint_stall_flag_d;
  reg  [EP_COUNT-1:0] pingpong_ptr_d;

  // -------------------------------------------------------------------------
  // Register port decode
  // -------------------------------------------------------------------------
  assign wr_top_flag = reg_wr && (reg_addr == `UBSI_ADDR_TOP_FLAG);
  assign wr_err_flag = reg_wr && (reg_addr == `UBSI_ADDR_ERR_FLAG);
  assign wr_stall    = reg_wr && (reg_addr == `UBSI_ADDR_EP_STALL);
  assign engine_active = usb_control_reg_q[`UBSI_CTRL_ENGINE_EN] &&
                         power_control_reg_q[`UBSI_PWR_ENGINE];
  assign txn_take    = txn_valid && engine_active;
  assign stall_event = txn_take && (eval_result == `UBSI_RES_STALL);
  assign done_event  = txn_take && (eval_result == `UBSI_RES_DONE);
  assign ep_onehot   = {{(EP_COUNT-1){1'b0}}, 1'b1} << txn_endpoint;
  assign wr_desc_lo  = reg_wr && (reg_addr == `UBSI_ADDR_DESC_LO);
  assign wr_desc_hi  = reg_wr && (reg_addr == `UBSI_ADDR_DESC_HI);
  // Any enabled error flag feeds the top-level summary.
  assign error_pending = |(error_irq_flag_reg_q & error_irq_enable_reg_q);

  // -------------------------------------------------------------------------
  // Flag clear and set masks
  // -------------------------------------------------------------------------
  assign top_clear   = wr_top_flag ? reg_wdata : 8'h00;
  assign error_clear = wr_err_flag ? reg_wdata : 8'h00;
  // Only the low eight endpoints are reachable from the register port.
  assign stall_clear = wr_stall ? {{(EP_COUNT-8){1'b0}}, reg_wdata} : {EP_COUNT{1'b0}};
  assign stall_set   = stall_event ? ep_onehot : {EP_COUNT{1'b0}};

  // -------------------------------------------------------------------------
  // Descriptor evaluation
  // -------------------------------------------------------------------------
  ubsi_desc_eval u_eval (
    .desc_word    (descriptor_status_word_q),
    .host_mode    (txn_host_mode),
    .token_pid    (txn_token_pid),
    .result_pid   (txn_result_pid),
    .data_toggle  (txn_toggle),
    .actual_count (txn_count),
    .result       (eval_result),
    .new_word     (eval_word)
  );

  // -------------------------------------------------------------------------
  // Descriptor status word
  // -------------------------------------------------------------------------
  // The engine update wins over a CPU write in the same cycle.
  // Software must not write an engine-owned word; no guard is kept against it.
  always @* begin
    descriptor_status_word_d = descriptor_status_word_q;
    if (done_event) begin
      descriptor_status_word_d = eval_word;
    end else if (wr_desc_lo) begin
      descriptor_status_word_d[7:0] = reg_wdata;
    end else if (wr_desc_hi) begin
      descriptor_status_word_d[15:8] = reg_wdata;
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      descriptor_status_word_q <= 16'h0000;
    end else begin
      descriptor_status_word_q <= descriptor_status_word_d;
    end
  end

  // -------------------------------------------------------------------------
  // Transaction answer
  // -------------------------------------------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      txn_done          <= 1'b0;
      txn_result        <= `UBSI_RES_IDLE;
      status_phase_auto <= 1'b0;
    end else begin
      txn_done   <= txn_take;
      txn_result <= txn_take ? eval_result : `UBSI_RES_IDLE;
      // RULE16 - automatic status phase
      status_phase_auto <= done_event && !txn_host_mode && txn_is_setup;
    end
  end

  // -------------------------------------------------------------------------
  // Endpoint stall flags
  // -------------------------------------------------------------------------
  // RULE12 - stall flag set
  // RULE15 - set wins clear
  always @* begin
    endpoint_stall_flag_d = (endpoint_stall_flag_q & ~stall_clear) | stall_set;
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      endpoint_stall_flag_q <= {EP_COUNT{1'b0}};
    end else begin
      endpoint_stall_flag_q <= endpoint_stall_flag_d;
    end
  end

  // -------------------------------------------------------------------------
  // Interrupt flags
  // -------------------------------------------------------------------------
  // RULE14 - error summary
  // RULE24 - transfer done flag
  assign top_set = {stall_event, 3'h0, done_event, 1'b0, error_pending, 1'b0};

  // Hardware events win over a write-one clear in the same cycle, so no event is lost.
  // The summary is set again each cycle while an enabled error flag is pending.
  // RULE15 - write one clears
  always @* begin
    error_irq_flag_reg_d = (error_irq_flag_reg_q & ~error_clear) | err_events;
    top_irq_flag_reg_d   = (top_irq_flag_reg_q & ~top_clear) | top_set;
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      error_irq_flag_reg_q <= `UBSI_RESET_BYTE;
      top_irq_flag_reg_q   <= `UBSI_RESET_BYTE;
    end else begin
      error_irq_flag_reg_q <= error_irq_flag_reg_d;
      top_irq_flag_reg_q   <= top_irq_flag_reg_d;
    end
  end

  // RULE13 - single request line
  assign irq = |(top_irq_flag_reg_q & top_irq_enable_reg_q);

  // -------------------------------------------------------------------------
  // Control registers
  // -------------------------------------------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      top_irq_enable_reg_q        <= `UBSI_RESET_BYTE;
      error_irq_enable_reg_q      <= `UBSI_RESET_BYTE;
      usb_control_reg_q           <= `UBSI_RESET_BYTE;
      on_the_go_control_reg_q     <= `UBSI_RESET_BYTE;
      endpoint_zero_control_reg_q <= `UBSI_RESET_BYTE;
      power_control_reg_q         <= `UBSI_RESET_BYTE;
    end else if (reg_wr) begin
      case (reg_addr)
        `UBSI_ADDR_TOP_EN:   top_irq_enable_reg_q        <= reg_wdata;
        `UBSI_ADDR_ERR_EN:   error_irq_enable_reg_q      <= reg_wdata;
        `UBSI_ADDR_USB_CTRL: usb_control_reg_q           <= reg_wdata;
        `UBSI_ADDR_OTG_CTRL: on_the_go_control_reg_q     <= reg_wdata;
        `UBSI_ADDR_EP0_CTRL: endpoint_zero_control_reg_q <= reg_wdata;
        `UBSI_ADDR_PWR_CTRL: power_control_reg_q         <= reg_wdata;
        default: begin
        end
      endcase
    end
  end

  // RULE22 - pull-up drive
  assign dplus_pullup_enable = on_the_go_control_reg_q[`UBSI_OTG_DPLUS_PULLUP];

  // -------------------------------------------------------------------------
  // Ping-pong pointers
  // -------------------------------------------------------------------------
  // The reset bit acts as a level: pointers stay at zero while it is set, so
  // the set-then-clear sequence leaves them in their initial state.
  // RULE17 - pointer reset
  always @* begin
    pingpong_ptr_d = pingpong_ptr_q;
    if (usb_control_reg_q[`UBSI_CTRL_PP_RESET]) begin
      pingpong_ptr_d = {EP_COUNT{1'b0}};
    end else if (done_event) begin
      pingpong_ptr_d = pingpong_ptr_q ^ ep_onehot;
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      pingpong_ptr_q <= {EP_COUNT{1'b0}};
    end else begin
      pingpong_ptr_q <= pingpong_ptr_d;
    end
  end

  // -------------------------------------------------------------------------
  // Read port
  // -------------------------------------------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `UBSI_ADDR_TOP_FLAG: reg_rdata <= top_irq_flag_reg_q;
        `UBSI_ADDR_TOP_EN:   reg_rdata <= top_irq_enable_reg_q;
        `UBSI_ADDR_ERR_FLAG: reg_rdata <= error_irq_flag_reg_q;
        `UBSI_ADDR_ERR_EN:   reg_rdata <= error_irq_enable_reg_q;
        `UBSI_ADDR_USB_CTRL: reg_rdata <= usb_control_reg_q;
        `UBSI_ADDR_OTG_CTRL: reg_rdata <= on_the_go_control_reg_q;
        `UBSI_ADDR_EP0_CTRL: reg_rdata <= endpoint_zero_control_reg_q;
        `UBSI_ADDR_PWR_CTRL: reg_rdata <= power_control_reg_q;
        `UBSI_ADDR_EP_STALL: reg_rdata <= endpoint_stall_flag_q[7:0];
        `UBSI_ADDR_PP_PTR:   reg_rdata <= pingpong_ptr_q[7:0];
        `UBSI_ADDR_DESC_LO:  reg_rdata <= descriptor_status_word_q[7:0];
        `UBSI_ADDR_DESC_HI:  reg_rdata <= descriptor_status_word_q[15:8];
        default:             reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule // ubsi_core

// file: verification/ubsi_core_monitor.sv
// Port assertions for the descriptor status and interrupt block.
`timescale 1ns/10ps
`include "ubsi_map.vh"
module ubsi_core_monitor (
  input wire       clk,
  input wire       sys_rst,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_rdata,
  input wire       txn_valid,
  input wire       txn_host_mode,
  input wire       txn_is_setup,
  input wire       txn_done,
  input wire [1:0] txn_result,
  input wire       status_phase_auto,
  input wire       irq,
  input wire       dplus_pullup_enable,
  input wire       engine_active
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire go = txn_valid && engine_active;
  a_done_taken:
    assert property (go |=> txn_done) else $error("done missing");
  a_done_quiet:
    assert property (!go |=> !txn_done) else $error("done without cause");
  a_status_cause:
    assert property (status_phase_auto |-> txn_done && txn_result == `UBSI_RES_DONE
      && $past(txn_is_setup && !txn_host_mode)) else $error("bad status phase");
  a_pullup_bit:
    assert property (reg_wr && reg_addr == `UBSI_ADDR_OTG_CTRL |=>
      dplus_pullup_enable == $past(reg_wdata[7])) else $error("pull-up wrong");
  a_usb_off:
    assert property (reg_wr && reg_addr == `UBSI_ADDR_USB_CTRL && !reg_wdata[0] |=>
      !engine_active) else $error("engine still active");
  a_power_off:
    assert property (reg_wr && reg_addr == `UBSI_ADDR_PWR_CTRL && !reg_wdata[0] |=>
      !engine_active) else $error("engine still powered");
  a_mask_all:
    assert property (reg_wr && reg_addr == `UBSI_ADDR_TOP_EN && reg_wdata == 8'h00
      |=> !irq) else $error("irq while masked");
  a_ep0_back:
    assert property (reg_wr && reg_addr == `UBSI_ADDR_EP0_CTRL ##1 !reg_wr ##1 reg_rd
      && reg_addr == `UBSI_ADDR_EP0_CTRL |=> reg_rdata == $past(reg_wdata, 3))
      else $error("readback wrong");
  a_irq_reset:
    assert property ($past(sys_rst) |-> !irq) else $error("irq after reset");
endmodule // ubsi_core_monitor
bind ubsi_core ubsi_core_monitor u_mon (.clk, .sys_rst, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .txn_valid, .txn_host_mode, .txn_is_setup,
  .txn_done, .txn_result, .status_phase_auto, .irq, .dplus_pullup_enable,
  .engine_active);

// file: verification/ubsi_usb_host.sv
// Behavioural bus partner that hands decoded transactions to the engine.
`timescale 1ns/10ps
module ubsi_usb_host (
  input  wire       clk,
  output reg        txn_valid,
  output reg  [3:0] txn_endpoint,
  output reg  [3:0] txn_token_pid,
  output reg  [3:0] txn_result_pid,
  output reg        txn_toggle,
  output reg  [9:0] txn_count,
  output reg        txn_host_mode,
  output reg        txn_is_setup
);
  initial begin
    txn_valid = 1'b0;
    {txn_endpoint, txn_token_pid, txn_result_pid, txn_toggle} = 13'h0000;
    {txn_count, txn_host_mode, txn_is_setup} = 12'h000;
  end
  task send(input [3:0] ep, input [3:0] tok, input [3:0] res, input tgl,
            input [9:0] cnt, input host, input setup);
    txn_valid <= 1'b1;
    {txn_endpoint, txn_token_pid, txn_result_pid, txn_toggle} <= {ep, tok, res, tgl};
    {txn_count, txn_host_mode, txn_is_setup} <= {cnt, host, setup};
    @(posedge clk);
    txn_valid <= 1'b0;
    // Released qualifiers show the inverse of their last value.
    {txn_endpoint, txn_token_pid, txn_result_pid, txn_toggle} <= ~{ep, tok, res, tgl};
    {txn_count, txn_host_mode, txn_is_setup} <= ~{cnt, host, setup};
  endtask
endmodule // ubsi_usb_host

// file: verification/usb_bd_status_irq_ctrl_tb_top.sv
// Self-checking bench comparing the block with a bench model.
`timescale 1ns/10ps
`include "ubsi_map.vh"
module usb_bd_status_irq_ctrl_tb_top;
  reg         clk        = 1'b0;
  reg         sys_rst    = 1'b1;
  reg  [7:0]  reg_addr   = 8'h00;
  reg  [7:0]  reg_wdata  = 8'h00;
  reg         reg_wr     = 1'b0;
  reg         reg_rd     = 1'b0;
  reg  [7:0]  err_events = 8'h00;
  reg  [15:0] rnd        = 16'h0035;
  reg  [15:0] desc, exp_w;
  reg  [7:0]  exp_f;
  reg  [1:0]  exp_r;
  reg         tg;
  wire [7:0]  reg_rdata;
  wire [3:0]  txn_endpoint, txn_token_pid, txn_result_pid;
  wire [9:0]  txn_count;
  wire [1:0]  txn_result;
  wire        txn_valid, txn_toggle, txn_host_mode, txn_is_setup, txn_done;
  wire        status_phase_auto, irq, dplus_pullup_enable, engine_active;
  integer     errors = 0;
  integer     n_tests = 0;
  integer     i;
  integer     pp_model = 0;
  reg  [15:0] exp_q [$];
  ubsi_usb_host u_host (.clk, .txn_valid, .txn_endpoint, .txn_token_pid,
    .txn_result_pid, .txn_toggle, .txn_count, .txn_host_mode, .txn_is_setup);
  ubsi_core u_dut (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .txn_valid, .txn_endpoint, .txn_token_pid, .txn_result_pid,
    .txn_toggle, .txn_count, .txn_host_mode, .txn_is_setup, .err_events, .txn_done,
    .txn_result, .status_phase_auto, .irq, .dplus_pullup_enable, .engine_active);
  always #5 clk = ~clk;
  function [15:0] lfsr(input [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task check(input [15:0] seen, input [15:0] expv, input [8*8:1] what);
    n_tests = n_tests + 1;
    if (seen !== expv) begin
      errors = errors + 1;
      $display("Error %0s expected %h seen %h", what, expv, seen);
    end
  endtask
  task finish_test;
    $display("Checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task wr(input [7:0] a, input [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task rdc(input [7:0] a, input [7:0] expv);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, expv, "rdata");
    @(posedge clk);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    for (i = 0; i < 13; i = i + 1)
      rdc(i[7:0], 8'h00);
    wr(`UBSI_ADDR_USB_CTRL, 8'h02);
    wr(`UBSI_ADDR_USB_CTRL, 8'h00);
    wr(`UBSI_ADDR_TOP_EN, 8'h00);
    wr(`UBSI_ADDR_ERR_EN, 8'h00);
    wr(`UBSI_ADDR_TOP_FLAG, 8'hFF);
    wr(`UBSI_ADDR_ERR_FLAG, 8'hFF);
    wr(`UBSI_ADDR_USB_CTRL, 8'h01);
    wr(`UBSI_ADDR_OTG_CTRL, 8'h04);
    wr(`UBSI_ADDR_EP0_CTRL, 8'h09);
    rdc(`UBSI_ADDR_EP0_CTRL, 8'h09);
    check(engine_active, 1'b0, "active");
    wr(`UBSI_ADDR_PWR_CTRL, 8'h01);
    check(engine_active, 1'b1, "active");
    check(dplus_pullup_enable, 1'b0, "pullup");
    wr(`UBSI_ADDR_OTG_CTRL, 8'h84);
    check(dplus_pullup_enable, 1'b1, "pullup");
    wr(`UBSI_ADDR_TOP_EN, 8'h8A);
    wr(8'h0C, 8'hFF);
    rdc(8'h0C, 8'h00);
    for (i = 0; i < 5; i = i + 1) begin
      rnd = lfsr(rnd);
      tg = rnd[0];
      desc = {i != 4, tg, 2'b00, i == 2, i == 3, 10'h040};
      exp_r = (i == 4) ? `UBSI_RES_IDLE : (i == 3) ? `UBSI_RES_STALL :
              (i == 2) ? `UBSI_RES_IGNORE : `UBSI_RES_DONE;
      exp_w = (exp_r != `UBSI_RES_DONE) ? desc :
              {1'b0, tg ^ (i == 0), (i == 1) ? rnd[15:12] : rnd[13:10], rnd[9:0]};
      exp_f = (exp_r == `UBSI_RES_DONE) ? 8'h08 : {exp_r == `UBSI_RES_STALL, 7'h00};
      exp_q.push_back(exp_w);
      if (exp_r == `UBSI_RES_DONE)
        pp_model = pp_model ^ (1 << i);
      // Low byte first so the ownership bit in the high byte is written last.
      // ownership bit written last
      wr(`UBSI_ADDR_DESC_LO, desc[7:0]);
      wr(`UBSI_ADDR_DESC_HI, desc[15:8]);
      u_host.send(i[3:0], rnd[13:10], rnd[15:12], tg ^ (i == 0 || i == 2),
                  rnd[9:0], i == 1, i < 2);
      #1 check(txn_done, 1'b1, "done");
      check(txn_result, exp_r, "result");
      check(status_phase_auto, i == 0, "status");
      check(irq, exp_f != 8'h00, "irq");
      @(posedge clk);
      exp_w = exp_q.pop_front();
      rdc(`UBSI_ADDR_DESC_HI, exp_w[15:8]);
      rdc(`UBSI_ADDR_DESC_LO, exp_w[7:0]);
      rdc(`UBSI_ADDR_EP_STALL, {4'h0, i == 3, 3'h0});
      wr(`UBSI_ADDR_TOP_FLAG, 8'h00);
      rdc(`UBSI_ADDR_TOP_FLAG, exp_f);
      wr(`UBSI_ADDR_TOP_FLAG, 8'hFF);
      wr(`UBSI_ADDR_EP_STALL, 8'hFF);
      rdc(`UBSI_ADDR_TOP_FLAG, 8'h00);
    end
    wr(`UBSI_ADDR_ERR_EN, 8'h01);
    err_events <= 8'h21;
    @(posedge clk);
    err_events <= 8'h00;
    @(posedge clk);
    rdc(`UBSI_ADDR_ERR_FLAG, 8'h21);
    rdc(`UBSI_ADDR_TOP_FLAG, 8'h02);
    check(irq, 1'b1, "irq");
    wr(`UBSI_ADDR_TOP_EN, 8'h00);
    check(irq, 1'b0, "irq");
    wr(`UBSI_ADDR_TOP_EN, 8'h8A);
    wr(`UBSI_ADDR_ERR_FLAG, 8'hFF);
    wr(`UBSI_ADDR_TOP_FLAG, 8'hFF);
    rdc(`UBSI_ADDR_TOP_FLAG, 8'h00);
    rdc(`UBSI_ADDR_PP_PTR, pp_model[7:0]);
    wr(`UBSI_ADDR_USB_CTRL, 8'h03);
    wr(`UBSI_ADDR_USB_CTRL, 8'h00);
    check(engine_active, 1'b0, "active");
    pp_model = 0;
    rdc(`UBSI_ADDR_PP_PTR, pp_model[7:0]);
    wr(`UBSI_ADDR_USB_CTRL, 8'h01);
    wr(`UBSI_ADDR_PWR_CTRL, 8'h00);
    u_host.send(4'h1, 4'h9, 4'h0, 1'b0, 10'h001, 1'b0, 1'b0);
    #1 check(txn_done, 1'b0, "done");
    finish_test;
  end
  initial begin
    repeat (20000) @(posedge clk);
    errors = errors + 1;
    finish_test;
  end
endmodule // usb_bd_status_irq_ctrl_tb_top
